// ### sfd_pkg.sv
// shared constants for the fault diagnostic readout block
package sfd_pkg;
    // ==========================================================
    // frame and word layout
    localparam int          SFD_NCH           = 8;            // driver channels
    localparam int          SFD_WORD_W        = 2 * SFD_NCH;  // status word bits
    localparam int          SFD_CNT_W         = 5;            // serial clock counter width
    localparam logic [4:0]  SFD_FIRST_BITS    = 5'd16;        // length of the first word
    localparam logic [4:0]  SFD_LATER_BITS    = 5'd8;         // length of each later word
    localparam logic [4:0]  SFD_CNT_WRAP      = 5'(SFD_FIRST_BITS + SFD_LATER_BITS - 5'd1);
    localparam logic [4:0]  SFD_CNT_ONE       = 5'd1;         // count after the first edge
    localparam logic [4:0]  SFD_CNT_ZERO      = 5'd0;
    localparam int          SFD_OL_OFS        = 1;            // open-load flag at odd bits
    localparam int          SFD_D_OFS         = 0;            // overload flag at even bits
    // ==========================================================
    // channel commands
    localparam logic [1:0]  SFD_CMD_STANDBY   = 2'b00;        // fast off, clears faults
    localparam logic [1:0]  SFD_CMD_INPUT     = 2'b01;        // parallel input, diag on
    localparam logic [1:0]  SFD_CMD_ON        = 2'b10;        // driver on
    localparam logic [1:0]  SFD_CMD_OFF       = 2'b11;        // driver off, diag on
    localparam logic [1:0]  SFD_MODE_RESET    = SFD_CMD_OFF;  // off after power-on
    // ==========================================================
    // synchroniser vector layout
    localparam int          SFD_SY_CSB        = 0;
    localparam int          SFD_SY_TOG        = 1;
    localparam int          SFD_SY_LHI        = 2;
    localparam int          SFD_SY_UNDERVOLTAGE_LOCKOUT_MODE       = 3;
    localparam int          SFD_SY_LOWIQ      = 4;
    localparam int          SFD_SY_GOFF       = 5;
    localparam int          SFD_SY_OT         = 6;
    localparam int          SFD_SY_OL         = 7;
    localparam int          SFD_SY_OVL        = SFD_SY_OL + SFD_NCH;
    localparam int          SFD_SY_W          = SFD_SY_OVL + SFD_NCH;
endpackage : sfd_pkg

// ### sfd_sync.sv
// two-stage synchroniser for a vector of independent levels
module sfd_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0    // idle level of each bit
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import sfd_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // ==========================================================
    // first stage is read only by the second
    always_comb begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= RST_VAL;                // reset to idle so no false edge follows
            sync_out <= RST_VAL;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end
endmodule : sfd_sync

// ### sfd_readout.sv
// fault diagnostic readout and channel fault latches behind the serial port
module sfd_readout #(
    parameter int NCH = sfd_pkg::SFD_NCH
) (
    input  wire logic           ref_clk_in,
    input  wire logic           rst_in,
    input  wire logic           serial_clk_in,
    input  wire logic           chip_select_low_in,
    input  wire logic           serial_in,
    output logic                serial_out_out,
    output logic                serial_out_oe_out,
    input  wire logic [NCH-1:0] open_load_det_in,
    input  wire logic [NCH-1:0] overload_det_in,
    input  wire logic           overtemp_det_in,
    input  wire logic           limp_home_input_in,
    input  wire logic           undervoltage_lockout_mode_in,
    input  wire logic           low_iq_mode_in,
    input  wire logic           global_off_mode_in,
    output logic      [NCH-1:0] driver_on_out,
    output logic      [NCH-1:0] diag_current_en_out
);
    import sfd_pkg::*;

    localparam int W = 2 * NCH;
    // chip select idles high, so its synchroniser stage resets high as well
    localparam logic [SFD_SY_W-1:0] SY_RST = SFD_SY_W'(1'b1) << SFD_SY_CSB;

    // ==========================================================
    // core domain state
    logic [SFD_SY_W-1:0]  sy;
    logic [W-1:0]         snap_word;
    logic                 snap_ter;
    logic                 transfer_error_flag;
    logic                 csb_d;
    logic                 tog_seen;
    logic [2:0]           ev_d;
    logic [NCH-1:0]       ol_flag;
    logic [NCH-1:0]       d_flag;
    logic [2*NCH-1:0]     mode;
    logic [W-1:0]         next_snap_word;
    logic                 next_snap_ter;
    logic                 next_ter;
    logic                 next_tog_seen;
    logic [2:0]           next_ev_d;
    logic [NCH-1:0]       next_ol_flag;
    logic [NCH-1:0]       next_d_flag;
    logic [2*NCH-1:0]     next_mode;
    logic [NCH-1:0]       next_drv;
    logic [NCH-1:0]       next_diag;
    logic                 s_csb;
    logic                 frame_end;
    logic                 frame_ok;
    logic                 mode_evt;
    logic [NCH-1:0]       ol_set;
    logic [NCH-1:0]       d_set;
    logic [NCH-1:0]       clr;

    // ==========================================================
    // link domain state
    logic                 started;
    logic                 head;
    logic                 so_bit;
    logic                 tog;
    logic [SFD_CNT_W-1:0] cnt;
    logic [W:0]           sr;
    logic [SFD_CNT_W-1:0] next_cnt;
    logic [W:0]           next_sr;
    logic                 next_tog;
    logic                 link_rst;

    // ==========================================================
    // synchronisers for pins and the frame toggle
    sfd_sync #(
        .WIDTH   (SFD_SY_W),
        .RST_VAL (SY_RST)
    ) u_sync (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .async_in ({overload_det_in, open_load_det_in, overtemp_det_in, global_off_mode_in,
                    low_iq_mode_in, undervoltage_lockout_mode_in, limp_home_input_in, tog,
                    chip_select_low_in}),
        .sync_out (sy)
    );

    // ==========================================================
    // link side: count clocks, shift status out and command in
    assign link_rst = rst_in | chip_select_low_in; // chip select high ends the frame

    always_comb begin
        if (!started) begin
            next_cnt = SFD_CNT_ONE;
            next_sr  = {snap_word, serial_in};
            next_tog = ~tog;                              // marks that a clock arrived
        end else begin
            next_cnt = (cnt == SFD_CNT_WRAP) ? SFD_FIRST_BITS
                                             : SFD_CNT_W'(cnt + SFD_CNT_ONE);
            next_sr  = {sr[W-1:0], serial_in};
            next_tog = tog;
        end
    end

    // counter and shifter survive chip select so the core can read them after the frame
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= SFD_CNT_ZERO;
            sr  <= '0;
            tog <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sr  <= next_sr;
            tog <= next_tog;
        end
    end

    // first-edge marker, cleared whenever chip select is high
    always_ff @(posedge serial_clk_in or posedge link_rst) begin
        if (link_rst) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // output bits change on the falling clock
    always_ff @(negedge serial_clk_in or posedge link_rst) begin
        if (link_rst) begin
            head   <= 1'b1;
            so_bit <= 1'b0;
        end else begin
            head   <= 1'b0;
            so_bit <= sr[W];
        end
    end

    // error flag leads until the first falling clock
    assign serial_out_out    = head ? snap_ter : so_bit;
    assign serial_out_oe_out = ~chip_select_low_in;

    // ==========================================================
    // core side: frame checking, fault latches, channel modes
    always_comb begin
        s_csb     = sy[SFD_SY_CSB];
        frame_end = s_csb & ~csb_d;                       // synced pin went high
        frame_ok  = frame_end && (sy[SFD_SY_TOG] != tog_seen)
                    && (cnt == SFD_FIRST_BITS);
        next_ev_d = {sy[SFD_SY_LOWIQ], sy[SFD_SY_UNDERVOLTAGE_LOCKOUT_MODE], sy[SFD_SY_LHI]};
        mode_evt  = (ev_d[0] & ~sy[SFD_SY_LHI]) | (ev_d[1] & ~sy[SFD_SY_UNDERVOLTAGE_LOCKOUT_MODE])
                    | (ev_d[2] & sy[SFD_SY_GOFF]);
        next_tog_seen = frame_end ? sy[SFD_SY_TOG] : tog_seen;
        if (mode_evt) begin
            next_ter = 1'b1;
        end else if (frame_end) begin
            next_ter = ~frame_ok;
        end else begin
            next_ter = transfer_error_flag;
        end
        next_mode      = mode;
        next_snap_word = snap_word;
        next_snap_ter  = snap_ter;
        for (int i = 0; i < NCH; i++) begin
            clr[i]    = frame_ok && (sr[2*i+1 -: 2] == SFD_CMD_STANDBY);
            ol_set[i] = sy[SFD_SY_OL+i] && !driver_on_out[i]
                        && diag_current_en_out[i];
            d_set[i]  = driver_on_out[i]
                        && (sy[SFD_SY_OVL+i] || sy[SFD_SY_OT]);
            next_ol_flag[i] = ol_set[i] | (ol_flag[i] & ~clr[i]); // set wins
            next_d_flag[i]  = d_set[i] | (d_flag[i] & ~clr[i]);
            if (frame_ok) begin
                next_mode[2*i+1 -: 2] = sr[2*i+1 -: 2];
            end
            next_drv[i]  = (next_mode[2*i+1 -: 2] == SFD_CMD_ON) && !next_d_flag[i];
            if (frame_ok) begin
                next_diag[i] = (sr[2*i+1 -: 2] == SFD_CMD_INPUT)
                               || (sr[2*i+1 -: 2] == SFD_CMD_OFF);
            end else begin
                next_diag[i] = diag_current_en_out[i];
            end
            if (s_csb) begin
                next_snap_word[2*i+SFD_OL_OFS] = ol_flag[i];
                next_snap_word[2*i+SFD_D_OFS]  = d_flag[i];
            end
        end
        if (s_csb) begin
            next_snap_ter = transfer_error_flag;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            csb_d               <= 1'b1;
            tog_seen            <= 1'b0;
            ev_d                <= '0;
            transfer_error_flag                 <= 1'b1;
            snap_ter            <= 1'b1;
            snap_word           <= '0;
            ol_flag             <= '0;
            d_flag              <= '0;
            mode                <= {NCH{SFD_MODE_RESET}};
            driver_on_out       <= '0;
            diag_current_en_out <= '0;                    // off after power-on
        end else begin
            csb_d               <= s_csb;
            tog_seen            <= next_tog_seen;
            ev_d                <= next_ev_d;
            transfer_error_flag                 <= next_ter;
            snap_ter            <= next_snap_ter;
            snap_word           <= next_snap_word;
            ol_flag             <= next_ol_flag;
            d_flag              <= next_d_flag;
            mode                <= next_mode;
            driver_on_out       <= next_drv;
            diag_current_en_out <= next_diag;
        end
    end

    // ==========================================================
    // checks on the core side
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence in_frame;
        !s_csb ##1 !s_csb;
    endsequence
    sequence limp_exit;
        sy[SFD_SY_LHI] ##1 !sy[SFD_SY_LHI];
    endsequence

    AST_NO_DRIVE_ON_FAULT: assert property (!(|(driver_on_out & d_flag)))
        else $error("driver on while its overload flag is set");
    AST_LIMP_EXIT_TER: assert property (limp_exit |=> transfer_error_flag)
        else $error("limp home exit did not set error flag");
    AST_GOOD_FRAME_CLR: assert property (frame_ok && !mode_evt |=> !transfer_error_flag)
        else $error("valid frame did not clear error flag");
    AST_BAD_FRAME_SET: assert property (frame_end && !frame_ok |=> transfer_error_flag)
        else $error("bad frame length did not set error flag");
    AST_CMD_CLEAR: assert property (clr[0] && !ol_set[0] && !d_set[0] |=> !ol_flag[0] && !d_flag[0])
        else $error("standby command did not clear channel faults");
    AST_OL_HOLD: assert property (ol_flag[0] && !clr[0] |=> ol_flag[0])
        else $error("open-load flag dropped without a clear");
    AST_SNAP_FROZEN: assert property (in_frame |-> $stable(snap_word) && $stable(snap_ter))
        else $error("status snapshot changed inside a frame");
    AST_SNAP_LAYOUT: assert property (s_csb |=> snap_word[SFD_OL_OFS] == $past(ol_flag[0])
                                      && snap_word[SFD_D_OFS] == $past(d_flag[0]))
        else $error("status word bit layout wrong");
    AST_OL_WHEN_OFF: assert property ($rose(ol_flag[0]) |-> !$past(driver_on_out[0]) && $past(diag_current_en_out[0]))
        else $error("open-load latched while driver on or diag off");
    AST_OVL_LATCH: assert property (sy[SFD_SY_OVL+1] && driver_on_out[1] |=> d_flag[1] && !driver_on_out[1])
        else $error("overload on an active channel not latched off");
    AST_OT_LATCH: assert property (sy[SFD_SY_OT] && driver_on_out[2] |=> d_flag[2] && !driver_on_out[2])
        else $error("overtemperature not latched");
endmodule : sfd_readout

// ### sfd_host_model.sv
// host serial master model that clocks frames into the readout block
module sfd_host_model (
    output logic      chip_select_low_out,
    output logic      serial_clk_out,
    output logic      serial_data_out,
    input  wire logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // idle state: deselected, serial clock parked low
    initial begin
        chip_select_low_out = 1'b1;
        serial_clk_out      = 1'b0;
        serial_data_out     = 1'b0;
    end

    // ==========================================================
    // one frame of n clocks at 30 ns, msb first; data changes on the falling edge
    task automatic xfer(input int n, input logic [31:0] cmd, output logic [32:0] rx);
        rx = '0;
        chip_select_low_out = 1'b0;
        #150;                                      // let the core snapshot the error flag
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_out = cmd[i];
            #15;
            rx = {rx[31:0], serial_data_in};       // bit shown since the last fall
            serial_clk_out = 1'b1;
            #15;
            serial_clk_out = 1'b0;
        end
        #15;
        rx = {rx[31:0], serial_data_in};
        chip_select_low_out = 1'b1;
        serial_data_out = ~serial_data_out;        // released line stops showing the last bit
        #150;                                      // gap so the core sees the frame end
    endtask : xfer
endmodule : sfd_host_model

// ### tb_spi_fault_diagnostic_readout.sv
// self-checking bench for the fault diagnostic readout block
module tb_spi_fault_diagnostic_readout;
    timeunit 1ns;
    timeprecision 1ps;
    import sfd_pkg::*;

    logic        ref_clk_in;
    logic        rst_in;
    logic        sclk;
    logic        csb_low;
    logic        mosi;
    logic        so;
    logic        so_oe;
    logic [7:0]  ol;
    logic [7:0]  ovl;
    logic        ot;
    logic [3:0]  mode_lvl;
    logic [7:0]  drv_on;
    logic [7:0]  diag_en;
    logic [32:0] last_rx;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cyc       = 0;

    // ==========================================================
    // clock and timeout watchdog
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    sfd_readout u_sfd_readout (
        .ref_clk_in                   (ref_clk_in),
        .rst_in                       (rst_in),
        .serial_clk_in                (sclk),
        .chip_select_low_in           (csb_low),
        .serial_in                    (mosi),
        .serial_out_out               (so),
        .serial_out_oe_out            (so_oe),
        .open_load_det_in             (ol),
        .overload_det_in              (ovl),
        .overtemp_det_in              (ot),
        .limp_home_input_in           (mode_lvl[0]),
        .undervoltage_lockout_mode_in (mode_lvl[1]),
        .low_iq_mode_in               (mode_lvl[2]),
        .global_off_mode_in           (mode_lvl[3]),
        .driver_on_out                (drv_on),
        .diag_current_en_out          (diag_en)
    );

    sfd_host_model u_sfd_host_model (
        .chip_select_low_out (csb_low),
        .serial_clk_out      (sclk),
        .serial_data_out     (mosi),
        .serial_data_in      (so_oe ? so : ~so)
    );

    // ==========================================================
    // comparisons and the closing report
    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic summarize();
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // frame with expected error flag and status word, then let the core settle
    task automatic frame(input int n, input logic [31:0] cmd, input logic transfer_error_flag, input logic [15:0] word);
        logic [32:0] rx;
        u_sfd_host_model.xfer(n, cmd, rx);
        last_rx = rx;
        chk_word("out enable", 16'h0000, {15'h0000, so_oe});
        chk_word("error flag", {15'h0000, transfer_error_flag}, {15'h0000, rx[n]});
        if (n >= 16) begin
            chk_word("status word", word, 16'(rx >> (n - 16)));
        end
        repeat (8) @(negedge ref_clk_in);
    endtask : frame

    // fault detector pulse of six core cycles
    task automatic inject(input logic [7:0] o, input logic [7:0] v, input logic t);
        @(negedge ref_clk_in);
        {ol, ovl, ot} = {o, v, t};
        repeat (6) @(negedge ref_clk_in);
        {ol, ovl, ot} = '0;
        repeat (6) @(negedge ref_clk_in);
    endtask : inject

    // enter one mode level, move to a second, then leave both
    task automatic modes(input logic [3:0] a, input logic [3:0] b);
        @(negedge ref_clk_in);
        mode_lvl = a;
        repeat (6) @(negedge ref_clk_in);
        mode_lvl = b;
        repeat (6) @(negedge ref_clk_in);
        mode_lvl = 4'h0;
        repeat (6) @(negedge ref_clk_in);
    endtask : modes

    // ==========================================================
    // main sequence
    initial begin
        rst_in   = 1'b1;
        {ol, ovl, ot} = '0;
        mode_lvl = 4'h0;
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (5) @(negedge ref_clk_in);
        frame(16, 32'hffff, 1'b1, 16'h0000);
        chk_word("diag enable", 16'h00ff, {8'h00, diag_en});
        fork
            frame(16, 32'hffff, 1'b0, 16'h0000);
            begin
                #400;
                inject(8'h05, 8'h00, 1'b0);
            end
        join
        frame(16, 32'hffef, 1'b0, 16'h0022);
        chk_word("driver on", 16'h0004, {8'h00, drv_on});
        frame(16, 32'hffec, 1'b0, 16'h0022);
        frame(16, 32'hffe8, 1'b0, 16'h0020);
        chk_word("driver on", 16'h0006, {8'h00, drv_on});
        inject(8'h00, 8'h02, 1'b0);
        chk_word("driver on", 16'h0004, {8'h00, drv_on});
        frame(16, 32'hffe8, 1'b0, 16'h0024);
        chk_word("driver on", 16'h0004, {8'h00, drv_on});
        inject(8'h00, 8'h00, 1'b1);
        chk_word("driver on", 16'h0000, {8'h00, drv_on});
        frame(16, 32'hffe8, 1'b0, 16'h0034);
        frame(16, 32'h0000, 1'b0, 16'h0034);
        frame(16, 32'hffff, 1'b0, 16'h0000);
        frame(15, 32'hffff, 1'b0, 16'h0000);
        frame(16, 32'hffff, 1'b1, 16'h0000);
        frame(24, 32'ha5ffff, 1'b0, 16'h0000);
        chk_word("daisy bits", 16'h00a5, {8'h00, last_rx[7:0]});
        frame(16, 32'hffff, 1'b0, 16'h0000);
        modes(4'h1, 4'h0);
        frame(16, 32'hffff, 1'b1, 16'h0000);
        modes(4'h2, 4'h0);
        frame(16, 32'hffff, 1'b1, 16'h0000);
        modes(4'h4, 4'h8);
        frame(16, 32'hffff, 1'b1, 16'h0000);
        frame(16, 32'hffff, 1'b0, 16'h0000);
        summarize();
    end
endmodule : tb_spi_fault_diagnostic_readout
